// ### hw/dsc_pkg.sv
package dsc_pkg;

  // Register word indices on the plain register port.
  localparam logic [3:0] DSC_CTRL_ADDR = 4'h0;
  localparam logic [3:0] DSC_STAT_ADDR = 4'h1;
  localparam logic [3:0] DSC_PINSEL_ADDR = 4'h2;
  localparam logic [3:0] DSC_IRQ_ADDR = 4'h3;

  // Control register fields.
  localparam int DSC_ARM_BIT = 0;
  localparam int DSC_DELAY_LSB = 16;
  localparam int DSC_DELAY_W = 16;
  localparam logic [15:0] DSC_DELAY_RST = 16'h0010;

  // Status register fields.
  localparam int DSC_DONE_BIT = 0;
  localparam int DSC_ASLEEP_BIT = 1;
  localparam int DSC_PIN_BIT = 2;
  localparam int DSC_OSC_BIT = 3;
  localparam int DSC_REF_BIT = 4;

  // Falling-edge event register: bit 0 is the flag, bit 1 the enable.
  localparam int DSC_FALL_FLAG_BIT = 0;
  localparam int DSC_FALL_EN_BIT = 1;

  // Shared pin function select codes.
  localparam logic [1:0] DSC_FN_SLEEP_IN = 2'h0;
  localparam logic [1:0] DSC_FN_ALARM_OUT = 2'h1;
  localparam logic [1:0] DSC_FN_GPIO = 2'h2;

  // Sequencer states.
  typedef enum logic [2:0] {
    DSC_ST_RUN,
    DSC_ST_GATE_REF,
    DSC_ST_OSC_OFF,
    DSC_ST_ASLEEP,
    DSC_ST_WAKE_CNT
  } dsc_state_e;

  // Register port request bundle.
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } dsc_req_s;

  // Clock controls that leave the block.
  typedef struct packed {
    logic ref_clk_en;
    logic osc_en;
  } dsc_clk_s;

endpackage : dsc_pkg

// ### hw/dsc_sync.sv
module dsc_sync (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_r;
  logic sync_r;

  // Two-stage synchroniser; resets high so an idle request line reads as awake.
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
    end
    else
    begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule : dsc_sync

// ### hw/dsc_wake_counter.sv
module dsc_wake_counter #(
  parameter int WIDTH = 16
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  input wire logic valid_in,
  input wire logic [WIDTH-1:0] limit_in,
  output logic reached_out
);

  logic [WIDTH-1:0] count_r;

  initial
  begin
    if (WIDTH < 1 || WIDTH > 32)
      $error("dsc_wake_counter: WIDTH out of range");
  end

  // Counts only valid oscillator cycles; clears whenever the wake phase is idle.
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      count_r <= '0;
    else if (!run_in)
      count_r <= '0;
    else if (valid_in && !reached_out)
      count_r <= count_r + WIDTH'(1);
  end

  assign reached_out = run_in && (count_r >= limit_in);

endmodule : dsc_wake_counter

// ### hw/dsc_deep_sleep.sv
// Operation
// - Low request while armed stops clocks, oscillator.
// - High request starts leaving sleep.
// - Register contents kept throughout sleep.
// - Request from external pin or alarm.
// - Request ignored while arm bit clear.
// - Writing arm one clears wake done.
// - Arming with request already low sleeps.
// - Gate reference clock, then oscillator off.
// - Wake re-enables oscillator, counts valid cycles.
// - Count reached: done set, reference on.
// - Writing arm zero clears wake done.
// - GPIO mode request still follows pin.
// - Function select; alarm mode drives low.
// - Alarm high drives wake from sleep.
// - PLL control contents survive sleep.
// - Handshake precedes sleep entry.
// - Pin falling edge raises event.
//
// Strobed register access and the register offsets were left to the implementer.
module dsc_deep_sleep #(
  parameter int DELAY_W = dsc_pkg::DSC_DELAY_W
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire dsc_pkg::dsc_req_s req_in,
  output logic [31:0] rdata_out,
  input wire logic sleep_request_pin_n_in,
  output logic sleep_request_pin_out,
  output logic sleep_request_pin_oe_out,
  input wire logic rtc_alarm_in,
  input wire logic osc_valid_in,
  output dsc_pkg::dsc_clk_s clk_ctl_out,
  output logic asleep_out,
  output logic fall_event_out
);

  logic sleep_arm_bit_r;
  logic wake_done_flag_r;
  logic [DELAY_W-1:0] wake_delay_field_r;
  logic [1:0] shared_pin_function_select_r;
  logic fall_en_r;
  logic fall_flag_r;
  logic req_prev_r;
  logic pin_drive_r;
  logic pin_oe_r;
  dsc_pkg::dsc_state_e state_r;
  dsc_pkg::dsc_state_e state_nxt;
  dsc_pkg::dsc_clk_s clk_r;
  logic asleep_r;
  logic req_raw;
  logic req_sync;
  logic reached;
  logic wr_ctrl;
  logic arm_set;
  logic arm_clr;

  initial
  begin
    if (DELAY_W < 1 || DELAY_W > 16)
      $error("dsc_deep_sleep: DELAY_W must be 1 to 16");
  end

  assign wr_ctrl = req_in.wr && (req_in.addr == dsc_pkg::DSC_CTRL_ADDR);
  // Every write of the arm bit clears the done flag unless completion coincides, so rewriting a one rearms after a wake.
  assign arm_set = wr_ctrl && req_in.wdata[dsc_pkg::DSC_ARM_BIT];
  assign arm_clr = wr_ctrl && !req_in.wdata[dsc_pkg::DSC_ARM_BIT];

  // The internal request is the pad level in input and GPIO modes, the alarm in alarm mode.
  // source selection
  always_comb
  begin
    if (shared_pin_function_select_r == dsc_pkg::DSC_FN_ALARM_OUT)
      req_raw = rtc_alarm_in;
    else
      req_raw = sleep_request_pin_n_in;
  end

  // The request is asynchronous to this clock, so it is synchronised first.
  // request synchroniser
  dsc_sync u_sync (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .async_in(req_raw),
    .sync_out(req_sync)
  );

  // Wake counter advances only while the oscillator reports valid cycles.
  // valid cycle counting
  dsc_wake_counter #(
    .WIDTH(DELAY_W)
  ) u_count (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .run_in(state_r == dsc_pkg::DSC_ST_WAKE_CNT),
    .valid_in(osc_valid_in),
    .limit_in(wake_delay_field_r),
    .reached_out(reached)
  );

  // Software-owned configuration; sleep never resets it so contents survive.
  // contents retained
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sleep_arm_bit_r <= 1'b0;
      wake_delay_field_r <= dsc_pkg::DSC_DELAY_RST[DELAY_W-1:0];
    end
    else if (wr_ctrl)
    begin
      sleep_arm_bit_r <= req_in.wdata[dsc_pkg::DSC_ARM_BIT];
      wake_delay_field_r <= req_in.wdata[dsc_pkg::DSC_DELAY_LSB +: DELAY_W];
    end
  end

  // Pin function and falling-edge enable.
  // function select
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      shared_pin_function_select_r <= dsc_pkg::DSC_FN_SLEEP_IN;
      fall_en_r <= 1'b0;
    end
    else
    begin
      if (req_in.wr && req_in.addr == dsc_pkg::DSC_PINSEL_ADDR)
        shared_pin_function_select_r <= req_in.wdata[1:0];
      if (req_in.wr && req_in.addr == dsc_pkg::DSC_IRQ_ADDR)
        fall_en_r <= req_in.wdata[dsc_pkg::DSC_FALL_EN_BIT];
    end
  end

  // Sequencer: entry gates the reference first, then stops the oscillator.
  // enter on low while armed
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      dsc_pkg::DSC_ST_RUN:
        if (sleep_arm_bit_r && !req_sync && !wake_done_flag_r)
          state_nxt = dsc_pkg::DSC_ST_GATE_REF;
      dsc_pkg::DSC_ST_GATE_REF:
        state_nxt = dsc_pkg::DSC_ST_OSC_OFF;
      dsc_pkg::DSC_ST_OSC_OFF:
        state_nxt = dsc_pkg::DSC_ST_ASLEEP;
      dsc_pkg::DSC_ST_ASLEEP:
        if (req_sync)
          state_nxt = dsc_pkg::DSC_ST_WAKE_CNT;
      dsc_pkg::DSC_ST_WAKE_CNT:
        if (reached)
          state_nxt = dsc_pkg::DSC_ST_RUN;
      default:
        state_nxt = dsc_pkg::DSC_ST_RUN;
    endcase
  end

  // State register.
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      state_r <= dsc_pkg::DSC_ST_RUN;
    else
      state_r <= state_nxt;
  end

  // Clock controls are registered so the outputs never glitch.
  // oscillator back on at wake
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      clk_r <= '{ref_clk_en: 1'b1, osc_en: 1'b1};
      asleep_r <= 1'b0;
    end
    else
    begin
      clk_r.ref_clk_en <= (state_nxt == dsc_pkg::DSC_ST_RUN);
      clk_r.osc_en <= (state_nxt != dsc_pkg::DSC_ST_OSC_OFF) &&
        (state_nxt != dsc_pkg::DSC_ST_ASLEEP);
      asleep_r <= (state_nxt != dsc_pkg::DSC_ST_RUN);
    end
  end

  // Done flag: completion set wins over a simultaneous arm-bit clear.
  // done set
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      wake_done_flag_r <= 1'b0;
    else if (state_r == dsc_pkg::DSC_ST_WAKE_CNT && reached)
      wake_done_flag_r <= 1'b1;
    else if (arm_set || arm_clr)
      wake_done_flag_r <= 1'b0;
  end

  // Falling edge of the synchronised request (pin, or alarm in alarm mode) raises a sticky event; set beats clear.
  // falling edge event
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      req_prev_r <= 1'b1;
      fall_flag_r <= 1'b0;
    end
    else
    begin
      req_prev_r <= req_sync;
      if (fall_en_r && req_prev_r && !req_sync)
        fall_flag_r <= 1'b1;
      else if (req_in.wr && req_in.addr == dsc_pkg::DSC_IRQ_ADDR &&
               req_in.wdata[dsc_pkg::DSC_FALL_FLAG_BIT])
        fall_flag_r <= 1'b0;
    end
  end

  // In alarm mode the pad is driven with the alarm level, low until it fires.
  // alarm output low
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pin_drive_r <= 1'b0;
      pin_oe_r <= 1'b0;
    end
    else
    begin
      pin_oe_r <= (shared_pin_function_select_r == dsc_pkg::DSC_FN_ALARM_OUT);
      pin_drive_r <= (shared_pin_function_select_r == dsc_pkg::DSC_FN_ALARM_OUT) &&
        rtc_alarm_in;
    end
  end

  // Read data stand in the cycle after the strobe only; zero otherwise.
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rdata_out <= 32'h0000_0000;
    else if (!req_in.rd)
      rdata_out <= 32'h0000_0000;
    else
    begin
      rdata_out <= 32'h0000_0000;
      unique case (req_in.addr)
        dsc_pkg::DSC_CTRL_ADDR:
        begin
          rdata_out[dsc_pkg::DSC_ARM_BIT] <= sleep_arm_bit_r;
          rdata_out[dsc_pkg::DSC_DELAY_LSB +: DELAY_W] <= wake_delay_field_r;
        end
        dsc_pkg::DSC_STAT_ADDR:
        begin
          rdata_out[dsc_pkg::DSC_DONE_BIT] <= wake_done_flag_r;
          rdata_out[dsc_pkg::DSC_ASLEEP_BIT] <= asleep_r;
          rdata_out[dsc_pkg::DSC_PIN_BIT] <= req_sync;
          rdata_out[dsc_pkg::DSC_OSC_BIT] <= clk_r.osc_en;
          rdata_out[dsc_pkg::DSC_REF_BIT] <= clk_r.ref_clk_en;
        end
        dsc_pkg::DSC_PINSEL_ADDR:
          rdata_out[1:0] <= shared_pin_function_select_r;
        dsc_pkg::DSC_IRQ_ADDR:
        begin
          rdata_out[dsc_pkg::DSC_FALL_FLAG_BIT] <= fall_flag_r;
          rdata_out[dsc_pkg::DSC_FALL_EN_BIT] <= fall_en_r;
        end
        default:
          rdata_out <= 32'h0000_0000;
      endcase
    end
  end

  assign clk_ctl_out = clk_r;
  assign asleep_out = asleep_r;
  assign fall_event_out = fall_flag_r;
  assign sleep_request_pin_out = pin_drive_r;
  assign sleep_request_pin_oe_out = pin_oe_r;

  // Sleep is entered only when armed and the request is low.
  // no entry unless armed
  guard_arm_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (state_r == dsc_pkg::DSC_ST_RUN && !sleep_arm_bit_r) |=> state_r == dsc_pkg::DSC_ST_RUN)
    else $error("Sleep entered while not armed");

  // Reference is gated one cycle before the oscillator stops.
  // ordered entry
  entry_order_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (state_r == dsc_pkg::DSC_ST_GATE_REF) |-> (!clk_r.ref_clk_en && clk_r.osc_en)
    ##1 (!clk_r.ref_clk_en && !clk_r.osc_en))
    else $error("Entry order broken");

  // Arming with the request low enters the reference gate next cycle and the asleep state two cycles after.
  // entry on low
  arm_enter_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (state_r == dsc_pkg::DSC_ST_RUN && sleep_arm_bit_r && !req_sync && !wake_done_flag_r)
    |=> state_r == dsc_pkg::DSC_ST_GATE_REF ##2 state_r == dsc_pkg::DSC_ST_ASLEEP)
    else $error("Armed low request did not enter sleep");

  // Request high while asleep restores the oscillator next cycle.
  // exit start
  wake_osc_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (state_r == dsc_pkg::DSC_ST_ASLEEP && req_sync) |=> clk_r.osc_en && !clk_r.ref_clk_en)
    else $error("Oscillator not enabled at wake");

  // Reaching the count sets the done flag and releases the reference together.
  // completion
  wake_done_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (state_r == dsc_pkg::DSC_ST_WAKE_CNT && reached) |=> wake_done_flag_r && clk_r.ref_clk_en
    && state_r == dsc_pkg::DSC_ST_RUN)
    else $error("Completion not signalled");

  // Any write of the arm bit clears the done flag unless completion coincides.
  // arm one clears
  done_clear_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    ((arm_set || arm_clr) && state_r != dsc_pkg::DSC_ST_WAKE_CNT) |=> !wake_done_flag_r)
    else $error("Done flag not cleared on arm write");

  // Alarm mode drives the pin with the alarm level.
  // alarm output
  alarm_pin_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (shared_pin_function_select_r == dsc_pkg::DSC_FN_ALARM_OUT && !rtc_alarm_in)
    |=> sleep_request_pin_oe_out && !sleep_request_pin_out)
    else $error("Alarm pin not driven low");

  // A falling request with the event enabled sets the flag.
  // falling edge
  fall_flag_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (fall_en_r && $fell(req_sync)) |=> fall_flag_r)
    else $error("Falling edge not flagged");

endmodule : dsc_deep_sleep

// ### verif/dsc_far_side.sv
// Stands in for the external power controller and the alarm source on the shared pad.
module dsc_far_side (
  input wire logic drive_low_in,
  input wire logic alarm_fire_in,
  input wire logic pad_oe_in,
  input wire logic pad_out_in,
  output logic pad_level_out,
  output logic alarm_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // the controller holds the request high until commanded low.
  // in alarm mode the device drives the pad, so the controller stays off it.
  // The design's drive wins, since two drivers fighting would hide a wrong enable.
  assign pad_level_out = pad_oe_in ? pad_out_in : ~drive_low_in;

  // the alarm source is a plain level, high once the alarm has fired.
  assign alarm_out = alarm_fire_in;

endmodule : dsc_far_side

// ### verif/deep_sleep_controller_test.sv
module deep_sleep_controller_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock_in;
  logic rst_n_in;
  dsc_pkg::dsc_req_s req;
  dsc_pkg::dsc_clk_s clk_ctl;
  logic [31:0] rdata;
  logic pad_n;
  logic pin_out;
  logic pin_oe;
  logic alarm;
  logic alarm_cmd;
  logic drive_low;
  logic osc_valid;
  logic asleep;
  logic fall_ev;
  int num_errors = 0;
  int checks_done = 0;
  int n;

  dsc_deep_sleep u_dut (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .req_in(req),
    .rdata_out(rdata),
    .sleep_request_pin_n_in(pad_n),
    .sleep_request_pin_out(pin_out),
    .sleep_request_pin_oe_out(pin_oe),
    .rtc_alarm_in(alarm),
    .osc_valid_in(osc_valid),
    .clk_ctl_out(clk_ctl),
    .asleep_out(asleep),
    .fall_event_out(fall_ev)
  );

  dsc_far_side u_far (
    .drive_low_in(drive_low),
    .alarm_fire_in(alarm_cmd),
    .pad_oe_in(pin_oe),
    .pad_out_in(pin_out),
    .pad_level_out(pad_n),
    .alarm_out(alarm)
  );

  // Free-running 125 MHz clock.
  initial
  begin
    clock_in = 1'h0;
    forever #4 clock_in = ~clock_in;
  end

  // One comparison of a value against its expectation.
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // Single-cycle write strobe beside address and data.
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_in);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'h1;
    @(posedge clock_in);
    req.wr <= 1'h0;
  endtask : reg_write

  // Read data stands only in the cycle after the strobe.
  task automatic reg_read(input logic [3:0] a, input logic [31:0] exp, input string name);
    @(posedge clock_in);
    req.addr <= a;
    req.rd <= 1'h1;
    @(posedge clock_in);
    req.rd <= 1'h0;
    #1;
    check(name, exp, rdata);
  endtask : reg_read

  function automatic logic sig(input int sel);
    case (sel)
      0: return asleep;
      1: return clk_ctl.ref_clk_en;
      2: return clk_ctl.osc_en;
      default: return fall_ev;
    endcase
  endfunction : sig

  // Bounded wait; a hang shows up as a failed check on the signal afterwards.
  task automatic wait_sig(input int sel, input logic val, output int cnt);
    cnt = 0;
    #1;
    while (cnt < 300 && sig(sel) !== val)
    begin
      @(posedge clock_in);
      #1;
      cnt++;
    end
  endtask : wait_sig

  task automatic final_report();
    if (num_errors == 0 && checks_done > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  // Watchdog sized well beyond the hundred or so cycles the sequence needs.
  initial
  begin
    repeat (20000) @(posedge clock_in);
    num_errors++;
    final_report();
  end

  // Main sequence.
  initial
  begin
    rst_n_in = 1'h0;
    req = '0;
    drive_low = 1'h0;
    alarm_cmd = 1'h0;
    osc_valid = 1'h1;
    repeat (16) @(posedge clock_in);
    rst_n_in <= 1'h1;
    reg_read(dsc_pkg::DSC_CTRL_ADDR, 32'h0010_0000, "ctrl reset");
    reg_read(dsc_pkg::DSC_STAT_ADDR, 32'h0000_001C, "status reset");
    reg_read(dsc_pkg::DSC_PINSEL_ADDR, 32'h0, "pinsel reset");
    reg_read(dsc_pkg::DSC_IRQ_ADDR, 32'h0, "event reset");
    reg_write(4'h7, 32'hFFFF_FFFF);
    reg_read(4'h7, 32'h0, "unmapped");
    // Request low while disarmed must be ignored.
    @(posedge clock_in);
    drive_low <= 1'h1;
    repeat (8) @(posedge clock_in);
    #1;
    check("disarmed", 32'h3, {29'h0, asleep, clk_ctl});
    // PLL bypass and power-down, memory and PHY parking are software steps
    // that leave no mark on this block, so the bench takes them as done before arming.
    // Arming with the request already low sleeps at once, reference first.
    // The delay is written on its own first, so it is settled before the arm bit rises.
    reg_write(dsc_pkg::DSC_CTRL_ADDR, 32'h0004_0000);
    reg_write(dsc_pkg::DSC_CTRL_ADDR, 32'h0004_0001);
    wait_sig(1, 1'h0, n);
    check("ref gated first", 32'h5, {29'h0, asleep, clk_ctl});
    @(posedge clock_in);
    #1;
    check("osc off", 32'h4, {29'h0, asleep, clk_ctl});
    reg_read(dsc_pkg::DSC_CTRL_ADDR, 32'h0004_0001, "ctrl kept");
    // Wake: only valid oscillator cycles advance the count.
    @(posedge clock_in);
    osc_valid <= 1'h0;
    drive_low <= 1'h0;
    wait_sig(2, 1'h1, n);
    check("osc back", 32'h1, {31'h0, clk_ctl.osc_en});
    repeat (10) @(posedge clock_in);
    #1;
    check("no valid cycles", 32'h0, {31'h0, clk_ctl.ref_clk_en});
    @(posedge clock_in);
    osc_valid <= 1'h1;
    wait_sig(1, 1'h1, n);
    // Four valid cycles reach the count, and the release follows one edge later.
    check("wake count", 32'h5, n);
    reg_read(dsc_pkg::DSC_STAT_ADDR, 32'h0000_001D, "done set");
    // memory restore after wake is software work outside this block.
    reg_write(dsc_pkg::DSC_CTRL_ADDR, 32'h0004_0000);
    reg_read(dsc_pkg::DSC_STAT_ADDR, 32'h0000_001C, "done cleared");
    // Alarm mode: pad driven low until the alarm, and the alarm wakes the device.
    reg_write(dsc_pkg::DSC_PINSEL_ADDR, 32'h1);
    repeat (2) @(posedge clock_in);
    #1;
    check("alarm pad low", 32'h2, {30'h0, pin_oe, pin_out});
    reg_write(dsc_pkg::DSC_CTRL_ADDR, 32'h0004_0001);
    wait_sig(0, 1'h1, n);
    check("alarm sleep", 32'h1, {31'h0, asleep});
    @(posedge clock_in);
    alarm_cmd <= 1'h1;
    wait_sig(0, 1'h0, n);
    check("alarm wake", 32'h3, {30'h0, pin_out, clk_ctl.ref_clk_en});
    reg_read(dsc_pkg::DSC_STAT_ADDR, 32'h0000_001D, "alarm done");
    reg_write(dsc_pkg::DSC_CTRL_ADDR, 32'h0004_0001);
    reg_read(dsc_pkg::DSC_STAT_ADDR, 32'h0000_001C, "arm clears done");
    reg_write(dsc_pkg::DSC_CTRL_ADDR, 32'h0004_0000);
    // General-purpose mode: pad still carries the request, falling edge flagged.
    reg_write(dsc_pkg::DSC_PINSEL_ADDR, 32'h2);
    reg_write(dsc_pkg::DSC_IRQ_ADDR, 32'h2);
    @(posedge clock_in);
    alarm_cmd <= 1'h0;
    drive_low <= 1'h1;
    wait_sig(3, 1'h1, n);
    check("fall event", 32'h2, {30'h0, fall_ev, asleep});
    check("pad released", 32'h0, {31'h0, pin_oe});
    reg_write(dsc_pkg::DSC_CTRL_ADDR, 32'h0004_0001);
    wait_sig(0, 1'h1, n);
    check("gpio sleep", 32'h1, {31'h0, asleep});
    reg_write(dsc_pkg::DSC_IRQ_ADDR, 32'h3);
    wait_sig(3, 1'h0, n);
    check("event cleared", 32'h0, {31'h0, fall_ev});
    @(posedge clock_in);
    drive_low <= 1'h0;
    wait_sig(0, 1'h0, n);
    check("gpio wake", 32'h1, {31'h0, clk_ctl.ref_clk_en});
    reg_write(dsc_pkg::DSC_CTRL_ADDR, 32'h0004_0000);
    final_report();
  end

endmodule : deep_sleep_controller_test
